//--- common/dqvrt_pkg.sv
// Constants and types for the data input reference training mode logic.
// Functional notes
// - Entry write ignores its six value bits; next training write supplies value.
// - Each later training write loads its six low bits as reference value.
// - Writing bit 7 as zero leaves training; bits 6:0 are ignored.
// - After exit, keep range and value of last seven-bit setting before exit.
package dqvrt_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 20;
  localparam int unsigned ENTRY_DELAY_NS      = 150;
  localparam int unsigned EXIT_DELAY_NS       = 150;
  localparam int unsigned STEP_TIME_NS        = 150;
  localparam int unsigned ENTRY_DELAY_CYC     = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXIT_DELAY_CYC      = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_TIME_CYC       = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned VALUE_W             = 6;
  localparam int unsigned SETTING_W           = 7;
  localparam int unsigned OPCODE_W            = 8;
  localparam int unsigned ENABLE_BIT          = 7;
  localparam int unsigned RANGE_BIT           = 6;
  localparam int unsigned CNT_W               = 8;
  localparam logic [SETTING_W-1:0] SETTING_RST = 7'h00;
  typedef enum logic [1:0] {
    DQVRT_IDLE,
    DQVRT_ENTRY_WAIT,
    DQVRT_TRAIN,
    DQVRT_EXIT_WAIT
  } dqvrt_state_e;
endpackage : dqvrt_pkg

//--- src/dqvrt_gap_timer.sv
// Down counter that marks a command gap as running.
module dqvrt_gap_timer #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_busy
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (i_load) begin
      cnt_d = i_count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_busy = (cnt_q != '0);
endmodule : dqvrt_gap_timer

//--- src/dqvrt_mode.sv
// Training mode logic for the data input reference, driven by mode register writes.
module dqvrt_mode
  import dqvrt_pkg::*;
(
  input  wire logic                           i_clock,
  input  wire logic                           i_rst,
  input  wire logic                           i_vref_mode_register_wr,
  input  wire logic [dqvrt_pkg::OPCODE_W-1:0] i_vref_mode_register_data,
  output logic                                o_training_active,
  output logic                                o_vref_range,
  output logic [dqvrt_pkg::VALUE_W-1:0]       o_data_input_reference,
  output logic                                o_entry_gap_busy,
  output logic                                o_exit_gap_busy,
  output logic                                o_step_busy
);
  import dqvrt_pkg::*;

  // ****************************************************************
  // Mode state and setting registers.
  // ****************************************************************
  dqvrt_state_e         state_q;
  dqvrt_state_e         state_d;
  logic                 active_q;
  logic                 active_d;
  logic                 range_q;
  logic                 range_d;
  logic [VALUE_W-1:0]   value_q;
  logic [VALUE_W-1:0]   value_d;

  // ****************************************************************
  // Gap timer status.
  // ****************************************************************
  logic                 entry_busy;
  logic                 exit_busy;
  logic                 step_busy;

  // ****************************************************************
  // Write fields.
  // ****************************************************************
  logic                 wr_en;
  logic                 wr_range;
  logic [VALUE_W-1:0]   wr_value;

  assign wr_en    = i_vref_mode_register_data[ENABLE_BIT];
  assign wr_range = i_vref_mode_register_data[RANGE_BIT];
  assign wr_value = i_vref_mode_register_data[VALUE_W-1:0];

  // ****************************************************************
  // Write classification.
  // ****************************************************************
  logic                 wr_entry;
  logic                 wr_step;
  logic                 wr_exit;

  assign wr_entry = i_vref_mode_register_wr && wr_en && !active_q;
  assign wr_step  = i_vref_mode_register_wr && wr_en && active_q;
  assign wr_exit  = i_vref_mode_register_wr && !wr_en && active_q;

  // ****************************************************************
  // Training flag.
  // ****************************************************************
  always_comb begin
    active_d = active_q;
    if (i_vref_mode_register_wr) begin
      active_d = wr_en;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  // ****************************************************************
  // Range and reference value setting.
  // ****************************************************************
  always_comb begin
    range_d = range_q;
    value_d = value_q;
    if (wr_entry) begin
      range_d = wr_range;
    end else if (wr_step) begin
      range_d = wr_range;
      value_d = wr_value;
    end else if (wr_exit) begin
      range_d = range_q;
      value_d = value_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      range_q <= SETTING_RST[RANGE_BIT];
      value_q <= SETTING_RST[VALUE_W-1:0];
    end else begin
      range_q <= range_d;
      value_q <= value_d;
    end
  end

  // ****************************************************************
  // Mode sequence.
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    if (wr_exit) begin
      state_d = DQVRT_EXIT_WAIT;
    end else if (wr_entry) begin
      state_d = DQVRT_ENTRY_WAIT;
    end else if (wr_step) begin
      state_d = DQVRT_TRAIN;
    end else if (!i_vref_mode_register_wr) begin
      unique case (state_q)
        DQVRT_IDLE: begin
          state_d = DQVRT_IDLE;
        end
        DQVRT_ENTRY_WAIT: begin
          if (!entry_busy) begin
            state_d = DQVRT_TRAIN;
          end
        end
        DQVRT_TRAIN: begin
          state_d = DQVRT_TRAIN;
        end
        DQVRT_EXIT_WAIT: begin
          if (!exit_busy) begin
            state_d = DQVRT_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= DQVRT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Gap lengths in clock cycles.
  // ****************************************************************
  localparam logic [CNT_W-1:0] ENTRY_LOAD = CNT_W'(ENTRY_DELAY_CYC);
  localparam logic [CNT_W-1:0] EXIT_LOAD  = CNT_W'(EXIT_DELAY_CYC);
  localparam logic [CNT_W-1:0] STEP_LOAD  = CNT_W'(STEP_TIME_CYC);

  // ****************************************************************
  // Gap timer after entry.
  // ****************************************************************
  dqvrt_gap_timer #(.CNT_W(CNT_W)) u_entry_gap (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (wr_entry),
    .i_count (ENTRY_LOAD),
    .o_busy  (entry_busy)
  );

  // ****************************************************************
  // Gap timer after exit.
  // ****************************************************************
  dqvrt_gap_timer #(.CNT_W(CNT_W)) u_exit_gap (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (wr_exit),
    .i_count (EXIT_LOAD),
    .o_busy  (exit_busy)
  );

  // ****************************************************************
  // Step time after each value write.
  // ****************************************************************
  dqvrt_gap_timer #(.CNT_W(CNT_W)) u_step_gap (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (wr_step),
    .i_count (STEP_LOAD),
    .o_busy  (step_busy)
  );

  // ****************************************************************
  // Output next values.
  // ****************************************************************
  logic                 out_active_d;
  logic                 out_range_d;
  logic [VALUE_W-1:0]   out_value_d;
  logic                 out_entry_busy_d;
  logic                 out_exit_busy_d;
  logic                 out_step_busy_d;

  always_comb begin
    out_active_d     = active_q;
    out_range_d      = range_q;
    out_value_d      = value_q;
    out_entry_busy_d = entry_busy;
    out_exit_busy_d  = exit_busy;
    out_step_busy_d  = step_busy;
  end

  // ****************************************************************
  // Output registers.
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_training_active      <= 1'b0;
      o_vref_range           <= SETTING_RST[RANGE_BIT];
      o_data_input_reference <= SETTING_RST[VALUE_W-1:0];
      o_entry_gap_busy       <= 1'b0;
      o_exit_gap_busy        <= 1'b0;
      o_step_busy            <= 1'b0;
    end else begin
      o_training_active      <= out_active_d;
      o_vref_range           <= out_range_d;
      o_data_input_reference <= out_value_d;
      o_entry_gap_busy       <= out_entry_busy_d;
      o_exit_gap_busy        <= out_exit_busy_d;
      o_step_busy            <= out_step_busy_d;
    end
  end
endmodule : dqvrt_mode

//--- sim/dqvrt_mode_assertions.sv
// Checker for the reference training mode logic.
module dqvrt_mode_assertions (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_vref_mode_register_wr,
  input  wire logic [7:0] i_vref_mode_register_data,
  input  wire logic       o_training_active,
  input  wire logic       o_vref_range,
  input  wire logic [5:0] o_data_input_reference,
  input  wire logic       o_entry_gap_busy,
  input  wire logic       o_exit_gap_busy,
  input  wire logic       o_step_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  wire       w = i_vref_mode_register_wr;
  wire [7:0] d = i_vref_mode_register_data;
  wire [5:0] v = o_data_input_reference;
  logic      a_q;
  wire       en = w && d[7] && !a_q;
  wire       st = w && d[7] && a_q;
  wire       ex = w && !d[7] && a_q;
  always_ff @(posedge i_clock) a_q <= i_rst ? 1'b0 : (w ? d[7] : a_q);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  flag_follow_a: assert property (w |-> ##2 o_training_active == $past(d[7], 2))
    else $error("flag wrong");
  entry_ignore_a: assert property (en |-> ##2 $stable(v))
    else $error("entry value used");
  value_load_a: assert property (st |-> ##2 v == $past(d[5:0], 2))
    else $error("value not loaded");
  exit_hold_a: assert property (w && !d[7] |-> ##2 $stable({o_vref_range, v}))
    else $error("exit changed setting");
  keep_setting_a: assert property ($fell(o_training_active) |-> $stable({o_vref_range, v}))
    else $error("setting lost");
  entry_gap_a: assert property (en |-> ##2 o_entry_gap_busy[*8])
    else $error("entry gap");
  step_gap_a: assert property (st |-> ##2 o_step_busy[*8])
    else $error("step gap");
  exit_gap_a: assert property (ex |-> ##2 o_exit_gap_busy[*8])
    else $error("exit gap");
  cover property (en);
  cover property (st);
  cover property (ex);
endmodule : dqvrt_mode_assertions
bind dqvrt_mode dqvrt_mode_assertions u_chk (.*);

//--- sim/dqvrt_ctrl_model.sv
// Controller model that sends reference mode register writes.
module dqvrt_ctrl_model (
  input  wire logic       i_clock,
  output logic            o_wr,
  output logic [7:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import dqvrt_pkg::*;
  localparam int unsigned EE_CYC =
    (ENTRY_DELAY_CYC > EXIT_DELAY_CYC) ? ENTRY_DELAY_CYC : EXIT_DELAY_CYC;
  localparam int unsigned GAP_CYC = (EE_CYC > STEP_TIME_CYC) ? EE_CYC : STEP_TIME_CYC;
  initial begin
    o_wr = 1'b0;
    o_data = 8'h00;
  end
  // Only mode register writes, each followed by GAP_CYC plus gap cycles of deselect.
  task automatic mode_register_set_cmd(input logic [7:0] d, input int gap);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_data <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_data <= ~d;
    repeat (GAP_CYC + gap) @(posedge i_clock);
  endtask : mode_register_set_cmd
  task automatic train(input logic r, input int n, input int gap, inout int seed);
    mode_register_set_cmd({1'b1, r, 6'($random(seed))}, gap);
    repeat (n) mode_register_set_cmd({1'b1, r, 6'($random(seed))}, gap);
    mode_register_set_cmd({1'b0, 7'($random(seed))}, gap);
  endtask : train
endmodule : dqvrt_ctrl_model

//--- sim/tb_top.sv
// Self-checking bench for the reference training mode logic.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dqvrt_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rst = 1'b1;
  logic       wr;
  logic [7:0] dat;
  logic       act;
  logic       rng;
  logic [5:0] val;
  logic       eb;
  logic       xb;
  logic       sb;
  int         bad_count, n_compared, ea, er, ev, ce, cx, cs, e;
  int         seed = 32'h6C64;
  int         q[$];
  initial forever #10 i_clock = ~i_clock;
  dqvrt_ctrl_model u_ctrl (.i_clock(i_clock), .o_wr(wr), .o_data(dat));
  dqvrt_mode i_dqvrt_mode (.i_clock(i_clock), .i_rst(i_rst), .i_vref_mode_register_wr(wr),
    .i_vref_mode_register_data(dat), .o_training_active(act), .o_vref_range(rng),
    .o_data_input_reference(val), .o_entry_gap_busy(eb), .o_exit_gap_busy(xb),
    .o_step_busy(sb));
  task automatic chk(input logic [7:0] got, input int exp);
    n_compared++;
    if (got !== 8'(exp)) begin
      bad_count++;
      $display("mismatch at %0t: state %h expected %h", $time, got, 8'(exp));
    end
  endtask : chk
  task automatic chk_gap(input logic [2:0] got, input int exp);
    n_compared++;
    if (got !== 3'(exp)) begin
      bad_count++;
      $display("mismatch at %0t: gap flags %h expected %h", $time, got, 3'(exp));
    end
  endtask : chk_gap
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  always @(posedge i_clock) begin
    if (i_rst) begin
      {ea, er, ev, ce, cx, cs} = '0;
      q = {};
    end else begin
      ce = (wr && dat[7] && ea == 0) ? ENTRY_DELAY_CYC : ((ce != 0) ? ce - 1 : 0);
      cs = (wr && dat[7] && ea != 0) ? STEP_TIME_CYC : ((cs != 0) ? cs - 1 : 0);
      cx = (wr && !dat[7] && ea != 0) ? EXIT_DELAY_CYC : ((cx != 0) ? cx - 1 : 0);
      if (wr && dat[7]) begin
        if (ea != 0) ev = dat[5:0];
        er = dat[6];
      end
      if (wr) ea = dat[7];
      q.push_back((ce != 0) * 1024 + (cx != 0) * 512 + (cs != 0) * 256 + ea * 128 + er * 64 + ev);
    end
  end
  always @(negedge i_clock) begin
    if (q.size() == 2) begin
      e = q.pop_front();
      chk({act, rng, val}, e[7:0]);
      chk_gap({eb, xb, sb}, e[10:8]);
    end
  end
  initial begin
    repeat (2000) @(posedge i_clock);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int r = 0; r < 2; r++) u_ctrl.train(r[0], 3, r ? 0 : STEP_TIME_CYC, seed);
    u_ctrl.mode_register_set_cmd({1'b0, 7'($random(seed))}, 2);
    u_ctrl.mode_register_set_cmd({2'b11, 6'($random(seed))}, 0);
    u_ctrl.mode_register_set_cmd({2'b11, 6'($random(seed))}, 0);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    u_ctrl.train(1'b0, 2, 0, seed);
    repeat (4) @(posedge i_clock);
    test_done();
  end
endmodule : tb_top
